// [design/err_report_regs.vh]
// register offsets, field positions and reset values for the error registers
`ifndef ERR_REPORT_REGS_VH
`define ERR_REPORT_REGS_VH
`define SEV_OFFSET        12'h10c
`define COR_FLAGS_OFFSET  12'h110
`define COR_MASKS_OFFSET  12'h114
`define CAP_CTRL_OFFSET   12'h118
`define HDR_LOG0_OFFSET   12'h11c
`define HDR_LOG1_OFFSET   12'h120
`define HDR_LOG2_OFFSET   12'h124
`define HDR_LOG3_OFFSET   12'h128
`define COR_FLAGS_RESET   32'h00000000
`define COR_MASKS_RESET   32'h00002000
`define CAP_CTRL_RESET    32'h000000a0
`define SEV_LOW_NIBBLE    4'h1
`define COR_IMPL_BITS     32'h000031c1
`define BIT_RX_ERR        0
`define BIT_TLP_DEC       6
`define BIT_DLLP_DEC      7
`define BIT_ROLLOVER      8
`define BIT_TIMER         12
`define BIT_ADVISORY      13
`define BIT_CHK_EN        8
`define BIT_CHK_CAP       7
`define BIT_GEN_EN        6
`define BIT_GEN_CAP       5
`endif

// [design/correctable_error_reporting_regs.v]
// correctable error status, mask and capability/control registers
`timescale 1ns/100ps
`include "err_report_regs.vh"

// How it works
// - flags stay set until written one
// - retransmit timer expiry sets bit 12
// - retransmit counter wrap sets bit 8
// - decode error in link packet sets 7
// - decode error in transaction packet sets 6
// - any decode error sets bit 0
// - advisory non-fatal report sets bit 13
// - mask blocks flag, message, log
// - mask resets to 0000 2000h
// - bit 8 enables crc checking, resets zero
// - bit 7 always reads one
// - bit 6 enables crc generation, resets zero
// - bit 5 always reads one
// - pointer records first uncorrectable error position
// - link, global, power-on resets restore defaults
// - reserved status/mask bits read zero
// - severity low bits read 0001b
// - control reserved bits zero, reset a0h
// - log captures latest error header
module correctable_error_reporting_regs (
   input  wire        clk,              // 25 mhz core clock
   input  wire        rst_b,            // power-on reset, active low
   input  wire        link_reset,       // fundamental link reset, sync
   input  wire        global_reset,     // global reset request, sync
   input  wire        cfg_wr,           // config write strobe, one cycle
   input  wire        cfg_rd,           // config read strobe, one cycle
   input  wire [11:0] cfg_addr,         // extended config byte address
   input  wire [3:0]  cfg_be,           // write byte enables
   input  wire [31:0] cfg_wdata,        // write data
   output reg  [31:0] cfg_rdata,        // read data, valid after cfg_rd
   output reg         cfg_rvalid,       // read data valid pulse
   input  wire        ev_retransmit_timer, // retransmit timer expired
   input  wire        ev_retransmit_wrap,  // retransmit counter wrapped
   input  wire        ev_decode_err,    // phy decode error, any time
   input  wire        rx_link_packet,   // link packet being received
   input  wire        rx_trans_packet,  // transaction packet being received
   input  wire        ev_advisory,      // advisory non-fatal reported
   input  wire        unc_err_valid,    // uncorrectable error detected
   input  wire [4:0]  unc_err_pos,      // its status bit position
   input  wire [31:0] unc_status,       // live uncorrectable flags
   input  wire [127:0] err_header,      // header of the erring packet
   output reg         cor_msg,          // correctable message request pulse
   output wire        end_to_end_crc_check_enable,    // check enable
   output wire        end_to_end_crc_generate_enable  // generate enable
);

   reg  [31:0] flags_r;
   reg  [31:0] masks_r;
   reg         chk_en_r;
   reg         gen_en_r;
   reg  [4:0]  first_err_r;
   reg  [127:0] hdr_log_r;
   reg  [31:0] wmask;
   reg  [31:0] ev_vec;
   reg  [31:0] rd_nxt;
   wire        soft_rst;
   wire [31:0] ev_taken;
   wire [31:0] cap_word;
   wire        wr_flags;
   wire        wr_masks;
   wire        wr_cap;
   integer     i;

   // link and global resets are synchronous clears on top of power-on
   assign soft_rst = link_reset | global_reset;

   // byte-enable expansion for writes
   always @*
   begin
      for (i = 0; i < 32; i = i + 1)
         wmask[i] = cfg_be[i / 8];
   end

   assign wr_flags = cfg_wr & (cfg_addr == `COR_FLAGS_OFFSET);
   assign wr_masks = cfg_wr & (cfg_addr == `COR_MASKS_OFFSET);
   assign wr_cap   = cfg_wr & (cfg_addr == `CAP_CTRL_OFFSET);

   // raw event vector at documented bit positions
   always @*
   begin
      ev_vec = 32'h00000000;
      ev_vec[`BIT_TIMER]    = ev_retransmit_timer;
      ev_vec[`BIT_ROLLOVER] = ev_retransmit_wrap;
      ev_vec[`BIT_DLLP_DEC] = ev_decode_err & rx_link_packet;
      ev_vec[`BIT_TLP_DEC]  = ev_decode_err & rx_trans_packet;
      ev_vec[`BIT_RX_ERR]   = ev_decode_err;
      ev_vec[`BIT_ADVISORY] = ev_advisory;
   end

   // masked events never reach flags or the message
   assign ev_taken = ev_vec & ~masks_r & `COR_IMPL_BITS;

   // status flags: set beats a same-cycle clear so no event is lost
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         flags_r <= `COR_FLAGS_RESET;
      else if (soft_rst)
         flags_r <= `COR_FLAGS_RESET;
      else if (wr_flags)
         flags_r <= (flags_r & ~(cfg_wdata & wmask)) | ev_taken;
      else
         flags_r <= flags_r | ev_taken;
   end

   // mask register, only implemented bits are writable
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         masks_r <= `COR_MASKS_RESET;
      else if (soft_rst)
         masks_r <= `COR_MASKS_RESET;
      else if (wr_masks)
         masks_r <= (masks_r & ~(wmask & `COR_IMPL_BITS)) |
                    (cfg_wdata & wmask & `COR_IMPL_BITS);
   end

   // crc enables in the low byte and bit 8
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         chk_en_r <= 1'b0;
         gen_en_r <= 1'b0;
      end
      else if (soft_rst)
      begin
         chk_en_r <= 1'b0;
         gen_en_r <= 1'b0;
      end
      else if (wr_cap)
      begin
         if (cfg_be[1])
            chk_en_r <= cfg_wdata[`BIT_CHK_EN];
         if (cfg_be[0])
            gen_en_r <= cfg_wdata[`BIT_GEN_EN];
      end
   end

   assign end_to_end_crc_check_enable    = chk_en_r;
   assign end_to_end_crc_generate_enable = gen_en_r;

   // first-error pointer; masking of uncorrectable errors is upstream,
   // so unc_err_valid arrives already filtered by that mask
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         first_err_r <= 5'h00;
      else if (soft_rst)
         first_err_r <= 5'h00;
      else if (unc_err_valid && (unc_status == 32'h00000000))
         first_err_r <= unc_err_pos;
   end

   // header log takes the newest unmasked error, corr or uncorr
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         hdr_log_r <= 128'h0;
      else if (soft_rst)
         hdr_log_r <= 128'h0;
      else if (unc_err_valid || (|ev_taken))
         hdr_log_r <= err_header;
   end

   // one message request per cycle with any unmasked event, except in a link or global reset cycle
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cor_msg <= 1'b0;
      else
         cor_msg <= (|ev_taken) & ~soft_rst;
   end

   assign cap_word = {23'h000000, chk_en_r, 1'b1, gen_en_r, 1'b1,
                      first_err_r};

   // read mux; unmapped offsets read zero
   always @*
   begin
      case (cfg_addr)
         `SEV_OFFSET:       rd_nxt = {28'h0000000, `SEV_LOW_NIBBLE};
         `COR_FLAGS_OFFSET: rd_nxt = flags_r & `COR_IMPL_BITS;
         `COR_MASKS_OFFSET: rd_nxt = masks_r & `COR_IMPL_BITS;
         `CAP_CTRL_OFFSET:  rd_nxt = cap_word;
         `HDR_LOG0_OFFSET:  rd_nxt = hdr_log_r[31:0];
         `HDR_LOG1_OFFSET:  rd_nxt = hdr_log_r[63:32];
         `HDR_LOG2_OFFSET:  rd_nxt = hdr_log_r[95:64];
         `HDR_LOG3_OFFSET:  rd_nxt = hdr_log_r[127:96];
         default:           rd_nxt = 32'h00000000;
      endcase
   end

   // registered read data, one cycle after the strobe
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_rdata  <= 32'h00000000;
         cfg_rvalid <= 1'b0;
      end
      else
      begin
         cfg_rvalid <= cfg_rd;
         if (cfg_rd)
            cfg_rdata <= rd_nxt;
      end
   end

endmodule // correctable_error_reporting_regs

// [verif/link_side_model.sv]
// far-side model: link and physical layer error events
`timescale 1ns/100ps
module link_side_model (
   input  wire       go,                  // raise one event now
   input  wire [2:0] code,                // which event
   output wire       ev_retransmit_timer, // timer expiry
   output wire       ev_retransmit_wrap,  // counter wrap
   output wire       ev_decode_err,       // decode error
   output wire       rx_link_packet,      // link packet in
   output wire       rx_trans_packet,     // transaction packet in
   output wire       ev_advisory          // advisory report
);
   // codes 2 to 4 are decode errors, qualified by what is arriving
   assign ev_retransmit_timer = go && code == 3'd0;
   assign ev_retransmit_wrap  = go && code == 3'd1;
   assign ev_decode_err       = go && code >= 3'd2 && code <= 3'd4;
   assign rx_link_packet      = go && code == 3'd2;
   assign rx_trans_packet     = go && code == 3'd3;
   assign ev_advisory         = go && code == 3'd5;
endmodule // link_side_model

// [verif/cor_err_sva.sv]
// assertions on the error register ports
`timescale 1ns/100ps
module cor_err_sva (
   input wire        clk,          // clock
   input wire        rst_b,        // reset, low
   input wire        link_reset,   // link reset
   input wire        global_reset, // global reset
   input wire        cfg_wr,       // write
   input wire        cfg_rd,       // read
   input wire [11:0] cfg_addr,     // address
   input wire        cfg_rvalid,   // read answer
   input wire        end_to_end_crc_check_enable,   // check on
   input wire        end_to_end_crc_generate_enable // generate on
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // only resets and control writes may move the enables
   wire rs = link_reset | global_reset;
   wire wc = cfg_wr && cfg_addr == 12'h118 && !rs;
   wire ce = end_to_end_crc_check_enable;
   wire ge = end_to_end_crc_generate_enable;
   chk_rst_ce: assert property (rs |=> !ce)
      else $error("check on after reset");
   chk_rst_ge: assert property (rs |=> !ge)
      else $error("generate on after reset");
   chk_hold_ce: assert property (!wc && !rs |=> $stable(ce))
      else $error("check moved");
   chk_hold_ge: assert property (!wc && !rs |=> $stable(ge))
      else $error("generate moved");
   chk_rise_ce: assert property ($rose(ce) |-> $past(wc))
      else $error("check rose unasked");
   chk_rise_ge: assert property ($rose(ge) |-> $past(wc))
      else $error("generate rose unasked");
   chk_read_ans: assert property (cfg_rd |=> cfg_rvalid)
      else $error("read not answered");
   chk_read_quiet: assert property (!cfg_rd |=> !cfg_rvalid)
      else $error("stray read answer");
endmodule // cor_err_sva
bind correctable_error_reporting_regs cor_err_sva cor_err_sva_inst (.*);

// [verif/test_correctable_error_reporting_regs.sv]
// self-checking bench for the correctable error registers
`timescale 1ns/100ps
module test_correctable_error_reporting_regs;
   reg          clk, rst_b, link_reset, global_reset, cfg_wr, cfg_rd, go;
   reg          unc_err_valid;
   reg  [2:0]   code, k;
   reg  [3:0]   cfg_be;
   reg  [4:0]   unc_err_pos;
   reg  [11:0]  cfg_addr;
   reg  [31:0]  cfg_wdata, unc_status, v;
   reg  [127:0] err_header;
   wire [31:0]  cfg_rdata;
   wire         cfg_rvalid, cor_msg, ev_retransmit_timer, ev_retransmit_wrap;
   wire         ev_decode_err, rx_link_packet, rx_trans_packet, ev_advisory;
   wire         end_to_end_crc_check_enable, end_to_end_crc_generate_enable;
   integer      err_count, checks, seed, i;
   // flags each event code must set
   wire [191:0] ev_tab = {32'h2000, 32'h1, 32'h41, 32'h81, 32'h100, 32'h1000};

   correctable_error_reporting_regs
      correctable_error_reporting_regs_inst (.*);
   link_side_model link_side_model_inst (.*);

   // 25 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task check(input [31:0] seen, input [31:0] exp);
   begin
      checks = checks + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
      end
   end
   endtask

   // one register cycle; a read is compared with d one cycle after it answers
   task cyc(input w, input r, input [11:0] a, input [31:0] d);
   begin
      @(posedge clk);
      cfg_wr <= w;
      cfg_rd <= r;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      cfg_rd <= 1'b0;
      @(posedge clk);
      #1 if (r) check(cfg_rdata, d);
   end
   endtask

   // one event cycle, message expected just after its edge
   task fire(input [2:0] c, input m);
   begin
      @(posedge clk);
      go <= 1'b1;
      code <= c;
      @(posedge clk);
      go <= 1'b0;
      #1 check({31'h0, cor_msg}, {31'h0, m});
   end
   endtask

   task give_verdict;
   begin
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask

   // watchdog, far beyond the expected run length
   initial
   begin
      #200000;
      err_count = err_count + 1;
      give_verdict;
   end

   initial
   begin
      seed = 22464;
      {link_reset, global_reset, cfg_wr, cfg_rd, go, code, unc_err_valid} = 0;
      {cfg_addr, cfg_wdata, unc_err_pos, unc_status, rst_b} = 0;
      {err_count, checks} = 0;
      cfg_be = 4'hf;
      err_header = {$random(seed), $random(seed), $random(seed), $random(seed)};
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      cyc(0, 1, 12'h110, 32'h0);
      cyc(0, 1, 12'h114, 32'h2000);
      cyc(0, 1, 12'h10c, 32'h1);
      cyc(0, 1, 12'h200, 32'h0);
      cyc(1, 0, 12'h118, 32'hffffffff);
      cyc(0, 1, 12'h118, 32'h1e0);
      cyc(1, 0, 12'h114, 32'h0);
      // each event alone; writing zero keeps a flag, writing one clears it
      for (i = 0; i < 6; i = i + 1)
      begin
         fire(i[2:0], 1'b1);
         cyc(0, 1, 12'h110, ev_tab[i*32+:32]);
         cyc(1, 0, 12'h110, 32'h0);
         cyc(0, 1, 12'h110, ev_tab[i*32+:32]);
         cyc(1, 0, 12'h110, 32'hffffffff);
         cyc(0, 1, 12'h110, 32'h0);
      end
      // random masks against random events
      for (i = 0; i < 40; i = i + 1)
      begin
         v = $random(seed);
         k = $unsigned($random(seed)) % 6;
         cyc(1, 0, 12'h114, v);
         cyc(0, 1, 12'h114, v & 32'h31c1);
         v = ev_tab[k*32+:32] & ~v;
         fire(k, |v);
         cyc(0, 1, 12'h110, v);
         cyc(1, 0, 12'h110, 32'hffffffff);
      end
      @(posedge clk);
      unc_err_valid <= 1'b1;
      unc_err_pos <= 5'h0c;
      @(posedge clk);
      unc_err_valid <= 1'b0;
      cyc(0, 1, 12'h118, 32'h1ec);
      cyc(0, 1, 12'h11c, err_header[31:0]);
      cyc(0, 1, 12'h128, err_header[127:96]);
      // a later error while one is still flagged: pointer holds, log moves
      @(posedge clk);
      unc_status <= 32'h00001000;
      unc_err_valid <= 1'b1;
      unc_err_pos <= 5'h03;
      err_header <= ~err_header;
      @(posedge clk);
      unc_err_valid <= 1'b0;
      cyc(0, 1, 12'h118, 32'h1ec);
      cyc(0, 1, 12'h124, err_header[95:64]);
      // link reset, then global reset
      for (i = 1; i < 3; i = i + 1)
      begin
         cyc(1, 0, 12'h118, 32'hffffffff);
         @(posedge clk);
         {global_reset, link_reset} <= i[1:0];
         @(posedge clk);
         {global_reset, link_reset} <= 2'b00;
         cyc(0, 1, 12'h118, 32'ha0);
         cyc(0, 1, 12'h114, 32'h2000);
      end
      give_verdict;
   end
endmodule // test_correctable_error_reporting_regs
